// ### src/event_counter.sv
/*
 * 16-bit timer/counter with byte access, oscillator enable, prescaler,
 * compare trigger reset and an overflow interrupt.
 * Assumes the register master obeys one-cycle strobes on core_clk and that
 * the external clock pins come from another domain.
 */
// Summary of operation
// (RL1) Byte reads during external counting are settled
// (RL2) Software handles overflow between two byte reads
// (RL3) Software stops counter before writing it async
// (RL4) Write racing increment: result undefined
// (RL5) Oscillator enable bit drives crystal amplifier
// (RL6) Oscillator keeps running during sleep
// (RL7) Software times oscillator start-up itself
// (RL8) Compare mode 1011 trigger resets counter
// (RL9) Trigger reset never sets overflow flag
// (RL10) Trigger reset needs timer or synced mode
// (RL11) Write in trigger cycle wins over reset
// (RL12) Compare pair acts as period register
// (RL13) Count 0000h to FFFFh, wrap, latch overflow
// (RL14) Unsynced external clock counts in sleep, wakes
// (RL15) Counter byte writes clear prescaler count
// (RL16) Reset initialises control, status and compare registers, never count
// (RL17) Trigger loads zero next edge, prescale kept
// (RL18) Async read path sampled into shadow at tick-free cycles
module event_counter (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    input wire logic osc_input_pin,
    input wire logic ext_clk_pin,
    input wire logic sleep_mode,
    input wire logic cmp_a_event,
    input wire logic cmp_b_event,
    output logic osc_output_pin,
    output logic osc_drive_en,
    output logic compare_trigger,
    output logic wake_request,
    output logic irq
);
    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [7:0] counter_control;   // Control register
    logic [15:0] count;            // The counter itself
    logic [1:0] status;            // Sticky event bits
    logic [1:0] mask;              // Interrupt mask
    logic [3:0] cmp_a_mode;        // Compare unit a mode field
    logic [3:0] cmp_b_mode;        // Compare unit b mode field
    logic [15:0] compare_value_pair; // Shared compare period
    logic [2:0] prescale_count;    // Input prescaler
    logic [15:0] read_shadow;      // Settled count for reads
    logic [1:0] pins_sync;         // Synchronised clock pins
    logic ext_prev;                // Previous selected pin level
    logic cmp_seen;                // Trigger already fired at match

    // ------------------------------------------------------------
    // Pin synchroniser
    // ------------------------------------------------------------
    pin_sync #(
        .WIDTH(2)
    ) u_pin_sync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .async_in({osc_input_pin, ext_clk_pin}),
        .sync_out(pins_sync)
    );

    // ------------------------------------------------------------
    // Control decode
    // ------------------------------------------------------------
    wire ctl_on = counter_control[count_pkg::CTL_ON_BIT];
    wire clock_source_select = counter_control[count_pkg::CTL_SRC_BIT];
    wire sync_disable_bit = counter_control[count_pkg::CTL_SYNC_DIS_BIT];
    wire osc_enable_bit = counter_control[count_pkg::CTL_OSC_EN_BIT];
    wire [1:0] ps_sel = counter_control[count_pkg::CTL_PS_LO_BIT +: 2];

    // Selected external input: crystal pin when oscillator runs
    wire ext_level = osc_enable_bit ? pins_sync[1] : pins_sync[0];
    wire ext_rise = ext_level & ~ext_prev;

    // Synchronised counting stops in sleep; unsynced keeps going (see RL14)
    wire async_mode = clock_source_select & sync_disable_bit;
    wire src_tick = clock_source_select ? (ext_rise & (async_mode | ~sleep_mode))
                                        : ~sleep_mode;

    // Prescaler terminal count for 1:1, 1:2, 1:4, 1:8
    function automatic logic [2:0] ps_limit(input logic [1:0] sel);
        ps_limit = 3'(({2'h0, 1'b1} << sel) - 3'h1);
    endfunction
    wire ps_done = (prescale_count == ps_limit(ps_sel));
    wire inc_tick = ctl_on & src_tick & ps_done;

    // ------------------------------------------------------------
    // Register port decode
    // ------------------------------------------------------------
    function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
        hit = (a == off);
    endfunction
    wire wr_low = reg_write & hit(reg_addr, count_pkg::ADDR_COUNT_LOW);
    wire wr_high = reg_write & hit(reg_addr, count_pkg::ADDR_COUNT_HIGH);
    wire wr_ctl = reg_write & hit(reg_addr, count_pkg::ADDR_CONTROL);
    wire wr_stat = reg_write & hit(reg_addr, count_pkg::ADDR_STATUS);
    wire wr_mask = reg_write & hit(reg_addr, count_pkg::ADDR_MASK);
    wire wr_cma = reg_write & hit(reg_addr, count_pkg::ADDR_CMP_A_MODE);
    wire wr_cmb = reg_write & hit(reg_addr, count_pkg::ADDR_CMP_B_MODE);
    wire wr_cpl = reg_write & hit(reg_addr, count_pkg::ADDR_CMP_LOW);
    wire wr_cph = reg_write & hit(reg_addr, count_pkg::ADDR_CMP_HIGH);
    wire wr_count = wr_low | wr_high;

    // ------------------------------------------------------------
    // Special event trigger
    // ------------------------------------------------------------
    // Either unit in trigger mode resets on a match or on its own event (see RL8)
    wire a_trig_mode = (cmp_a_mode == count_pkg::CMP_MODE_TRIGGER);
    wire b_trig_mode = (cmp_b_mode == count_pkg::CMP_MODE_TRIGGER);
    wire at_period = (count == compare_value_pair);
    wire match_event = at_period & ~cmp_seen & (a_trig_mode | b_trig_mode);
    wire trigger = match_event | (a_trig_mode & cmp_a_event)
                 | (b_trig_mode & cmp_b_event);
    // Async mode gives no reliable reset, so it is ignored there (see RL10)
    wire trig_reset = trigger & ~async_mode;

    // ------------------------------------------------------------
    // Next count
    // ------------------------------------------------------------
    wire wrap = inc_tick & (count == count_pkg::COUNT_MAX);
    wire [15:0] next_count =
        wr_low ? {count[15:8], reg_wdata} :           // Write wins (see RL11)
        wr_high ? {reg_wdata, count[7:0]} :           // Race with tick undefined (see RL4)
        trig_reset ? count_pkg::COUNT_ZERO :          // Zero next edge (see RL17)
        inc_tick ? 16'(count + 16'h0001) :            // Wraps to 0000h (see RL13)
        count;
    // Overflow only from a real wrap, never from trigger (see RL9)
    wire ovf_event = wrap & ~wr_count & ~trig_reset;
    wire [1:0] events = {trig_reset & ~wr_count, ovf_event};

    // Read mux; async counts come from the settled shadow (see RL1)
    wire [15:0] read_count = async_mode ? read_shadow : count;
    wire [7:0] next_rdata =
        hit(reg_addr, count_pkg::ADDR_COUNT_LOW) ? read_count[7:0] :
        hit(reg_addr, count_pkg::ADDR_COUNT_HIGH) ? read_count[15:8] :
        hit(reg_addr, count_pkg::ADDR_CONTROL) ? counter_control :
        hit(reg_addr, count_pkg::ADDR_STATUS) ? {6'h00, status} :
        hit(reg_addr, count_pkg::ADDR_MASK) ? {6'h00, mask} :
        hit(reg_addr, count_pkg::ADDR_CMP_A_MODE) ? {4'h0, cmp_a_mode} :
        hit(reg_addr, count_pkg::ADDR_CMP_B_MODE) ? {4'h0, cmp_b_mode} :
        hit(reg_addr, count_pkg::ADDR_CMP_LOW) ? compare_value_pair[7:0] :
        hit(reg_addr, count_pkg::ADDR_CMP_HIGH) ? compare_value_pair[15:8] :
        8'h00;

    // ------------------------------------------------------------
    // Control, mask and compare registers (device reset clears them, compare pair loads FFFFh)
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            counter_control <= count_pkg::CTL_RESET; // see RL16
            mask <= count_pkg::ST_RESET;
            cmp_a_mode <= 4'h0;
            cmp_b_mode <= 4'h0;
            compare_value_pair <= {count_pkg::CMP_RESET, count_pkg::CMP_RESET};
        end
        else
        begin
            if (wr_ctl)
                counter_control <= reg_wdata & count_pkg::CTL_WMASK;
            if (wr_mask)
                mask <= reg_wdata[1:0];
            if (wr_cma)
                cmp_a_mode <= reg_wdata[3:0];
            if (wr_cmb)
                cmp_b_mode <= reg_wdata[3:0];
            if (wr_cpl)
                compare_value_pair[7:0] <= reg_wdata;
            if (wr_cph)
                compare_value_pair[15:8] <= reg_wdata;
        end
    end

    // ------------------------------------------------------------
    // Counter: no reset; triggers and wrap clear it, byte writes load it (see RL16)
    // ------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        count <= next_count; // Period reached restarts at zero (see RL12)
    end

    // ------------------------------------------------------------
    // Prescaler and edge tracking
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prescale_count <= 3'h0;
            ext_prev <= 1'b0;
            cmp_seen <= 1'b0;
        end
        else
        begin
            ext_prev <= ext_level;
            cmp_seen <= at_period;
            if (wr_count)
                prescale_count <= 3'h0; // see RL15
            else if (ctl_on & src_tick)
                prescale_count <= ps_done ? 3'h0 : 3'(prescale_count + 3'h1);
        end
    end

    // ------------------------------------------------------------
    // Read shadow: the count as sampled at a tick-free cycle
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            read_shadow <= count_pkg::COUNT_ZERO;
        else if (!inc_tick)
            read_shadow <= count; // see RL18
    end

    // ------------------------------------------------------------
    // Sticky status: set wins over write-one-to-clear
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            status <= count_pkg::ST_RESET;
        else
            status <= (status & ~(wr_stat ? reg_wdata[1:0] : 2'h0)) | events; // see RL13
    end

    // ------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            reg_rdata <= 8'h00;
            osc_output_pin <= 1'b0;
            osc_drive_en <= 1'b0;
            compare_trigger <= 1'b0;
            wake_request <= 1'b0;
            irq <= 1'b0;
        end
        else
        begin
            reg_rdata <= reg_read ? next_rdata : 8'h00;
            // Amplifier inverts input while enabled, also in sleep (see RL5)
            osc_drive_en <= osc_enable_bit; // see RL6
            osc_output_pin <= osc_enable_bit & ~pins_sync[1];
            compare_trigger <= trig_reset;
            wake_request <= sleep_mode & ovf_event & async_mode; // see RL14
            irq <= |(status & mask);
        end
    end
endmodule

// ### shared/count_pkg.sv
/*
 * Package for the 16-bit counter block: register offsets, control field
 * positions, reset values, compare mode code and timing constants.
 * Assumes a plain register port with one-cycle strobes on core_clk.
 */
package count_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_COUNT_LOW = 4'h0;  // Low count byte
    localparam logic [3:0] ADDR_COUNT_HIGH = 4'h1; // High count byte
    localparam logic [3:0] ADDR_CONTROL = 4'h2;    // Counter control
    localparam logic [3:0] ADDR_STATUS = 4'h3;     // Sticky event status
    localparam logic [3:0] ADDR_MASK = 4'h4;       // Interrupt mask
    localparam logic [3:0] ADDR_CMP_A_MODE = 4'h5; // Compare unit a mode
    localparam logic [3:0] ADDR_CMP_B_MODE = 4'h6; // Compare unit b mode
    localparam logic [3:0] ADDR_CMP_LOW = 4'h7;    // Compare pair low byte
    localparam logic [3:0] ADDR_CMP_HIGH = 4'h8;   // Compare pair high byte

    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int CTL_ON_BIT = 0;       // Counter enable
    localparam int CTL_SRC_BIT = 1;      // Clock source select
    localparam int CTL_SYNC_DIS_BIT = 2; // Sync disable
    localparam int CTL_OSC_EN_BIT = 3;   // Oscillator enable
    localparam int CTL_PS_LO_BIT = 4;    // Prescale select low bit
    localparam logic [7:0] CTL_RESET = 8'h00;  // Value after reset
    localparam logic [7:0] CTL_WMASK = 8'h3F;  // Implemented bits

    // ------------------------------------------------------------
    // Status bits and other constants
    // ------------------------------------------------------------
    localparam int ST_OVF_BIT = 0;      // Overflow flag
    localparam int ST_TRIG_BIT = 1;     // Trigger reset seen
    localparam logic [1:0] ST_RESET = 2'h0;
    localparam logic [3:0] CMP_MODE_TRIGGER = 4'hB; // Special event mode
    localparam logic [15:0] COUNT_MAX = 16'hFFFF;
    localparam logic [15:0] COUNT_ZERO = 16'h0000;
    localparam logic [7:0] CMP_RESET = 8'hFF;
    localparam int OSC_MAX_KHZ = 200;   // Rated oscillator ceiling
    localparam int CORE_MHZ = 200;      // Core clock rate
    // Least core cycles per oscillator period, rounded up
    localparam int OSC_MIN_CYCLES = (CORE_MHZ * 1000 + OSC_MAX_KHZ - 1) / OSC_MAX_KHZ;
endpackage

// ### src/pin_sync.sv
/*
 * Two-flop synchroniser for a group of level inputs.
 * Assumes inputs are from outside core_clk; first stage read by second only.
 */
module pin_sync #(
    parameter int WIDTH = 2
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    // First stage, read by the second stage only
    logic [WIDTH-1:0] meta;

    // Two stages of flops
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta <= async_in;
            sync_out <= meta;
        end
    end
endmodule

// ### testbench/event_counter_chk.sv
/*
 * Port checker for the counter block.
 * Assumes it is bound to event_counter and sees only its ports.
 */
module event_counter_chk (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_rdata,
    input wire logic sleep_mode,
    input wire logic osc_output_pin,
    input wire logic osc_drive_en,
    input wire logic compare_trigger,
    input wire logic wake_request,
    input wire logic irq
);
    default clocking dc @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    wire logic osc_bit; // Oscillator bit of a write
    assign osc_bit = reg_wdata[count_pkg::CTL_OSC_EN_BIT];
    // Control write, then one quiet cycle
    sequence s_ctl_wr;
        reg_write && reg_addr == count_pkg::ADDR_CONTROL ##1 !reg_write;
    endsequence
    // Mask cleared to zero
    sequence s_mask_clr;
        reg_write && reg_addr == count_pkg::ADDR_MASK && reg_wdata == 8'h00;
    endsequence
    a_osc_drive: assert property (
        s_ctl_wr |=> osc_drive_en == $past(osc_bit, 2))
        else $error("Oscillator drive not following control");
    a_osc_quiet: assert property (
        !osc_drive_en |-> !osc_output_pin)
        else $error("Amplifier output active while disabled");
    a_rdata_idle: assert property (
        !reg_read |=> reg_rdata == 8'h00)
        else $error("Read data outside read cycle");
    a_unmapped_zero: assert property (
        reg_read && reg_addr > count_pkg::ADDR_CMP_HIGH |=> reg_rdata == 8'h00)
        else $error("Unmapped read not zero");
    a_ctl_top_zero: assert property (
        reg_read && reg_addr == count_pkg::ADDR_CONTROL |=> reg_rdata[7:6] == 2'h0)
        else $error("Control top bits not zero");
    a_wake_sleep: assert property (
        wake_request |-> $past(sleep_mode))
        else $error("Wake request outside sleep");
    a_trig_pulse: assert property (
        compare_trigger |=> !compare_trigger)
        else $error("Trigger pulse longer than one cycle");
    a_mask_irq: assert property (
        s_mask_clr |-> ##2 !irq)
        else $error("Interrupt high with mask cleared");
endmodule

bind event_counter event_counter_chk i_event_counter_chk (.core_clk, .rst_n, .reg_addr,
    .reg_wdata, .reg_write, .reg_read, .reg_rdata, .sleep_mode, .osc_output_pin,
    .osc_drive_en, .compare_trigger, .wake_request, .irq);

// ### testbench/clk_source.sv
/*
 * Far side model: external clock source and crystal.
 * Assumes a 48 ns link period, unrelated in phase to core_clk.
 */
module clk_source (
    input wire logic run,
    input wire logic osc_drive_en,
    output logic ext_clk_pin,
    output logic osc_input_pin
);
    timeunit 1ns;
    timeprecision 100ps;
    // Both sources toggle each half period; idle sources stand low
    initial
    begin
        ext_clk_pin = 1'b0;
        osc_input_pin = 1'b0;
        #0.7;
        forever
        begin
            #24;
            ext_clk_pin = run ? ~ext_clk_pin : 1'b0;
            // Crystal swings while driven, sleep or not
            osc_input_pin = osc_drive_en ? ~osc_input_pin : 1'b0;
        end
    end
endmodule

// ### testbench/async_counter_access_and_trigger_reset_tb.sv
/*
 * Self-checking bench for the counter block with random corner cases.
 * Assumes count_pkg, the design, checker and clk_source compiled first.
 */
module async_counter_access_and_trigger_reset_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk, rst_n, reg_write, reg_read, sleep_mode, cmp_a_event, cmp_b_event, link_run;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, v, w, per;
    logic osc_input_pin, ext_clk_pin, osc_output_pin, osc_drive_en;
    logic compare_trigger, wake_request, irq;
    int mismatches, compares, n;

    event_counter i_event_counter (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_write,
        .reg_read, .reg_rdata, .osc_input_pin, .ext_clk_pin, .sleep_mode, .cmp_a_event,
        .cmp_b_event, .osc_output_pin, .osc_drive_en, .compare_trigger,
        .wake_request, .irq);
    clk_source i_clk_source (.run(link_run), .osc_drive_en, .ext_clk_pin, .osc_input_pin);

    // Core clock, 5 ns period
    initial
    begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // Expected control read: top bits unimplemented
    function automatic logic [7:0] ctl_view(input logic [7:0] d);
        return {2'b00, d[5:0]};
    endfunction

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_read <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic rchk(input logic [3:0] a, input logic [7:0] exp, input string what);
        rd(a, v);
        chk(what, 16'(v), 16'(exp));
    endtask
    // Both count bytes, written while stopped
    task automatic set_count(input logic [15:0] c);
        wr(count_pkg::ADDR_COUNT_LOW, c[7:0]);
        wr(count_pkg::ADDR_COUNT_HIGH, c[15:8]);
    endtask
    task automatic conclude();
        $display("Checks %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Watchdog against a hang
    initial
    begin
        #100000;
        mismatches++;
        conclude();
    end

    initial
    begin
        rst_n = 1'b0;
        reg_write = 1'b0;
        reg_read = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        sleep_mode = 1'b0;
        cmp_a_event = 1'b0;
        cmp_b_event = 1'b0;
        link_run = 1'b0;
        void'($urandom(32'ha180aae0));
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        rchk(count_pkg::ADDR_CONTROL, 8'h00, "control reset");
        // Timer mode wrap and interrupt
        set_count(16'hFFFE);
        wr(count_pkg::ADDR_MASK, 8'h01);
        wr(count_pkg::ADDR_CONTROL, 8'h01);
        repeat (8) @(posedge core_clk);
        rchk(count_pkg::ADDR_STATUS, 8'h01, "overflow");
        chk("irq", 16'(irq), 16'h0001);
        wr(count_pkg::ADDR_MASK, 8'h00);
        wr(count_pkg::ADDR_CONTROL, 8'h00);
        wr(count_pkg::ADDR_STATUS, 8'h03);
        rchk(count_pkg::ADDR_STATUS, 8'h00, "status clear");
        $display("test overflow done");
        // Compare pair as period, from each unit
        for (int u = 0; u < 2; u++)
        begin
            per = 8'h10 + 8'($urandom_range(47));
            w = 8'(u ? count_pkg::ADDR_CMP_B_MODE : count_pkg::ADDR_CMP_A_MODE);
            set_count(16'h0000);
            wr(count_pkg::ADDR_CMP_LOW, per);
            wr(count_pkg::ADDR_CMP_HIGH, 8'h00);
            wr(w[3:0], 8'(count_pkg::CMP_MODE_TRIGGER));
            wr(count_pkg::ADDR_CONTROL, 8'h01);
            repeat (80) @(posedge core_clk);
            repeat (8)
            begin
                repeat ($urandom_range(40)) @(posedge core_clk);
                rd(count_pkg::ADDR_COUNT_LOW, v);
                chk("period", 16'(v <= per), 16'h0001);
            end
            wr(count_pkg::ADDR_CONTROL, 8'h00);
            wr(w[3:0], 8'h00);
            rchk(count_pkg::ADDR_STATUS, 8'h02, "trigger flags");
            wr(count_pkg::ADDR_STATUS, 8'h03);
        end
        $display("test period done");
        // Trigger alone, then trigger against a write
        wr(count_pkg::ADDR_CMP_A_MODE, 8'(count_pkg::CMP_MODE_TRIGGER));
        wr(count_pkg::ADDR_CMP_B_MODE, 8'(count_pkg::CMP_MODE_TRIGGER));
        set_count(16'h0005);
        @(posedge core_clk);
        cmp_b_event <= 1'b1;
        @(posedge core_clk);
        cmp_b_event <= 1'b0;
        #1 chk("trigger out", 16'(compare_trigger), 16'h0001);
        rchk(count_pkg::ADDR_COUNT_LOW, 8'h00, "trigger zero");
        @(posedge core_clk);
        reg_write <= 1'b1;
        reg_addr <= count_pkg::ADDR_COUNT_LOW;
        reg_wdata <= 8'h5A;
        cmp_a_event <= 1'b1;
        @(posedge core_clk);
        reg_write <= 1'b0;
        cmp_a_event <= 1'b0;
        rchk(count_pkg::ADDR_COUNT_LOW, 8'h5A, "write wins");
        wr(count_pkg::ADDR_CMP_A_MODE, 8'h00);
        wr(count_pkg::ADDR_CMP_B_MODE, 8'h00);
        wr(count_pkg::ADDR_STATUS, 8'h03);
        $display("test trigger done");
        // Unsynchronised external counting, then wake from sleep
        set_count(16'h0000);
        link_run <= 1'b1;
        wr(count_pkg::ADDR_CONTROL, 8'h07);
        repeat (60) @(posedge core_clk);
        rd(count_pkg::ADDR_COUNT_LOW, v);
        repeat (60) @(posedge core_clk);
        rd(count_pkg::ADDR_COUNT_LOW, w);
        chk("async read", 16'(w > v && v != 8'h00), 16'h0001);
        wr(count_pkg::ADDR_CONTROL, 8'h06);
        set_count(16'hFFF8);
        sleep_mode <= 1'b1;
        wr(count_pkg::ADDR_CONTROL, 8'h07);
        n = 0;
        while (wake_request !== 1'b1 && n < 400)
        begin
            @(negedge core_clk);
            n++;
        end
        chk("wake", 16'(wake_request), 16'h0001);
        // Oscillator enabled while still asleep, then a start-up wait
        wr(count_pkg::ADDR_CONTROL, 8'h0F);
        repeat (count_pkg::OSC_MIN_CYCLES) @(negedge core_clk);
        chk("osc drive", 16'(osc_drive_en), 16'h0001);
        wr(count_pkg::ADDR_CONTROL, 8'h00);
        sleep_mode <= 1'b0;
        rchk(count_pkg::ADDR_STATUS, 8'h01, "sleep overflow");
        $display("test async done");
        // Random control values and unmapped offsets
        repeat (6)
        begin
            w = 8'($urandom);
            wr(count_pkg::ADDR_CONTROL, w);
            rchk(count_pkg::ADDR_CONTROL, ctl_view(w), "control");
            v = 8'h09 + 8'($urandom_range(6));
            wr(v[3:0], 8'($urandom));
            rchk(v[3:0], 8'h00, "unmapped");
        end
        wr(count_pkg::ADDR_CONTROL, 8'h00);
        $display("test random done");
        // Reset with the counter stopped keeps the count, clears control
        set_count(16'h1234);
        wr(count_pkg::ADDR_CONTROL, 8'h30);
        rst_n <= 1'b0;
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        rchk(count_pkg::ADDR_CONTROL, 8'h00, "control after reset");
        rchk(count_pkg::ADDR_COUNT_LOW, 8'h34, "count kept low");
        rchk(count_pkg::ADDR_COUNT_HIGH, 8'h12, "count kept high");
        $display("test reset done");
        conclude();
    end
endmodule
